// ==== rtl/pmui2c_bus_if.sv ====
`timescale 1ns/1ps
interface pmui2c_bus_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	wire scl = scl_oe ? scl_o : 1'b1;
	wire sda = (sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o) ? 1'b0 : 1'b1;
	modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface : pmui2c_bus_if

// ==== rtl/pmui2c_device.sv ====
`timescale 1ns/1ps
`include "pmui2c_map.svh"
module pmui2c_device
	import pmui2c_pkg::*;
#(
	parameter logic [6:0] DEV_ID = `PMUI2C_DEV_ID,
	parameter int AW = `PMUI2C_ADDR_W,
	parameter logic [`PMUI2C_NREGS*8-1:0] WMASK = {`PMUI2C_NREGS{8'hdf}}
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	pmui2c_bus_if.device bus,
	output logic [AW-1:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic hs_mode,
	output logic busy
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	pmui2c_state_e state;
	pmui2c_state_e after_ack;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic [AW-1:0] addr;
	logic ack_drive;
	logic tx_mode;
	logic sda_low;
	// No reset for the bank: writable bits never written read back unknown
	logic [7:0] regs [0:`PMUI2C_NREGS-1];
	wire scl_rise = scl_sync[1] && !scl_q;
	wire scl_fall = !scl_sync[1] && scl_q;
	wire start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
	wire stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
	wire [7:0] rx_byte = {shreg[6:0], sda_sync[1]};
	wire byte_done = scl_rise && bitcnt == 4'h7;
	wire sel_match = rx_byte[7:1] == DEV_ID;
	wire is_mcode = rx_byte[7:3] == `PMUI2C_MCODE_HI;
	wire [AW-1:0] addr_inc = addr + 1'b1;
	wire [7:0] wmask_sel = WMASK[addr*8 +: 8];
	// Reserved bits are masked on the way out so they always read zero
	wire [7:0] rd_byte = regs[addr] & wmask_sel;

	// Both lines reset high, their idle level, so no false edge follows reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], bus.scl};
			sda_sync <= {sda_sync[0], bus.sda};
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= PMUI2C_ST_IDLE;
			after_ack <= PMUI2C_ST_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			addr <= '0;
			ack_drive <= 1'b0;
			tx_mode <= 1'b0;
			sda_low <= 1'b0;
			reg_addr <= '0;
			reg_wdata <= 8'h00;
			reg_wr <= 1'b0;
			hs_mode <= 1'b0;
			busy <= 1'b0;
		end else begin
			reg_wr <= 1'b0;
			if (stop_det) begin
				state <= PMUI2C_ST_IDLE;
				sda_low <= 1'b0;
				hs_mode <= 1'b0;
				busy <= 1'b0;
			end else if (start_det) begin
				state <= PMUI2C_ST_SEL;
				bitcnt <= 4'h0;
				sda_low <= 1'b0;
				busy <= 1'b1;
			end else begin
				unique case (state)
					PMUI2C_ST_IDLE: begin
						sda_low <= 1'b0;
					end
					PMUI2C_ST_SEL, PMUI2C_ST_ADDR, PMUI2C_ST_WDATA: begin
						if (scl_rise) begin
							shreg <= rx_byte;
							bitcnt <= bitcnt + 4'h1;
						end
						if (byte_done) begin
							bitcnt <= 4'h0;
							state <= PMUI2C_ST_ACK;
							ack_drive <= 1'b1;
							tx_mode <= 1'b0;
							if (state == PMUI2C_ST_SEL) begin
								if (sel_match && rx_byte[0]) begin
									after_ack <= PMUI2C_ST_RDATA;
								end else if (sel_match) begin
									after_ack <= PMUI2C_ST_ADDR;
								end else begin
									if (is_mcode) begin
										hs_mode <= 1'b1;
									end
									ack_drive <= 1'b0;
									state <= PMUI2C_ST_IDLE;
								end
							end else if (state == PMUI2C_ST_ADDR) begin
								addr <= rx_byte[AW-1:0];
								after_ack <= PMUI2C_ST_WDATA;
							end else begin
								regs[addr] <= (regs[addr] & ~wmask_sel) | (rx_byte & wmask_sel);
								reg_addr <= addr;
								reg_wdata <= rx_byte & wmask_sel;
								reg_wr <= 1'b1;
								addr <= addr_inc;
								after_ack <= PMUI2C_ST_WDATA;
							end
						end
					end
					// Ninth bit: own ack after the eighth fall, or master's ack on the ninth rise
					PMUI2C_ST_ACK: begin
						if (scl_fall && !sda_low && !tx_mode) begin
							sda_low <= ack_drive;
						end else if (scl_fall && tx_mode) begin
							sda_low <= 1'b0;
						end else if (scl_rise && tx_mode) begin
							if (sda_sync[1]) begin
								state <= PMUI2C_ST_IDLE;
							end else begin
								state <= PMUI2C_ST_RDATA;
								after_ack <= PMUI2C_ST_RDATA;
							end
						end else if (scl_fall && sda_low) begin
							sda_low <= 1'b0;
							state <= after_ack;
							if (after_ack == PMUI2C_ST_RDATA) begin
								sda_low <= !rd_byte[7];
								shreg <= rd_byte;
								bitcnt <= 4'h0;
							end
						end
					end
					// Each bit moves a few cycles after SCL falls, well before the next rise
					PMUI2C_ST_RDATA: begin
						if (scl_fall) begin
							if (bitcnt == 4'h0) begin
								sda_low <= !rd_byte[7];
								shreg <= rd_byte;
							end else begin
								sda_low <= !shreg[7 - bitcnt[2:0]];
							end
						end
						if (scl_rise) begin
							if (bitcnt == 4'h7) begin
								bitcnt <= 4'h0;
								addr <= addr_inc;
								state <= PMUI2C_ST_ACK;
								tx_mode <= 1'b1;
							end else begin
								bitcnt <= bitcnt + 4'h1;
							end
						end
					end
					default: state <= PMUI2C_ST_IDLE;
				endcase
			end
		end
	end

	// First data bit of a read is set up on the ack-ending fall, so RDATA starts at bit 1
	always_comb begin
		bus.sda_s_o = 1'b0;
		bus.sda_s_oe = sda_low;
	end
endmodule : pmui2c_device

// ==== rtl/pmui2c_host.sv ====
`timescale 1ns/1ps
`include "pmui2c_map.svh"
module pmui2c_host
	import pmui2c_pkg::*;
#(
	parameter int HALF_CYC = `PMUI2C_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	pmui2c_bus_if.host bus,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [6:0] cmd_dev,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic [3:0] cmd_len,
	output logic cmd_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic nack
);
	pmui2c_hstate_e st;
	logic [15:0] tick;
	logic phase;
	logic [1:0] sda_sync;
	logic [3:0] bitn;
	logic [8:0] sh;
	logic [2:0] step;
	logic [3:0] left;
	logic [1:0] op;
	logic [7:0] rx;
	logic scl_r;
	logic sda_r;
	wire tick_hit = tick == HALF_CYC[15:0] - 16'h1;
	wire tick_mid = tick == {1'b0, HALF_CYC[15:1]};
	// Data and ack bits on SDA move only mid-way through the low phase, clear of both clock edges
	wire mid_drive = tick_mid && !scl_r && (st == PMUI2C_HS_TX || st == PMUI2C_HS_ACK || st == PMUI2C_HS_RX);
	wire ack_slot = st == PMUI2C_HS_RX && bitn == 4'h8;
	wire next_sda = (st == PMUI2C_HS_TX) ? sh[8] : ack_slot ? (left == 4'h0) : 1'b1;
	wire [7:0] sel_w = {cmd_dev, 1'b0};
	wire [7:0] sel_r = {cmd_dev, 1'b1};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 16'h0;
			phase <= 1'b0;
			sda_sync <= 2'h3;
		end else begin
			sda_sync <= {sda_sync[0], bus.sda};
			tick <= tick_hit ? 16'h0 : tick + 16'h1;
			if (tick_hit) begin
				phase <= !phase;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= PMUI2C_HS_IDLE;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			bitn <= 4'h0;
			sh <= 9'h000;
			step <= 3'h0;
			left <= 4'h0;
			op <= 2'h0;
			rx <= 8'h00;
			cmd_ready <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			nack <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			cmd_ready <= st == PMUI2C_HS_IDLE && !cmd_valid;
			if (mid_drive) begin
				sda_r <= next_sda;
			end
			if (tick_hit) begin
				unique case (st)
					PMUI2C_HS_IDLE: begin
						if (cmd_valid && !phase) begin
							op <= cmd_op;
							left <= cmd_len;
							nack <= 1'b0;
							sda_r <= 1'b0;
							st <= PMUI2C_HS_START;
						end
					end
					PMUI2C_HS_START: begin
						scl_r <= 1'b0;
						bitn <= 4'h0;
						step <= 3'h0;
						sh <= (op == `PMUI2C_CMD_HS) ? 9'h011 :
							(op == `PMUI2C_CMD_WRITE || op == `PMUI2C_CMD_READ) ? {sel_w, 1'b1} : {sel_r, 1'b1};
						st <= PMUI2C_HS_TX;
					end
					PMUI2C_HS_TX: begin
						if (!scl_r) begin
							scl_r <= 1'b1;
						end else begin
							scl_r <= 1'b0;
							sh <= {sh[7:0], 1'b1};
							bitn <= bitn + 4'h1;
							if (bitn == 4'h7) begin
								st <= PMUI2C_HS_ACK;
							end
						end
					end
					PMUI2C_HS_ACK: begin
						if (!scl_r) begin
							scl_r <= 1'b1;
						end else begin
							scl_r <= 1'b0;
							bitn <= 4'h0;
							if (sda_sync[1] && op != `PMUI2C_CMD_HS) begin
								nack <= 1'b1;
								st <= PMUI2C_HS_STOP;
							end else if (op == `PMUI2C_CMD_HS) begin
								op <= `PMUI2C_CMD_CUR_READ;
								st <= PMUI2C_HS_RSTART;
							end else if (step == 3'h0 && op == `PMUI2C_CMD_CUR_READ) begin
								st <= PMUI2C_HS_RX;
							end else if (step == 3'h0) begin
								sh <= {cmd_addr, 1'b1};
								step <= 3'h1;
								st <= PMUI2C_HS_TX;
							end else if (op == `PMUI2C_CMD_READ) begin
								op <= `PMUI2C_CMD_CUR_READ;
								st <= PMUI2C_HS_RSTART;
							end else if (step == 3'h1) begin
								sh <= {cmd_wdata, 1'b1};
								step <= 3'h2;
								st <= PMUI2C_HS_TX;
							end else if (left != 4'h0) begin
								sh <= {cmd_wdata, 1'b1};
								left <= left - 4'h1;
								st <= PMUI2C_HS_TX;
							end else begin
								st <= PMUI2C_HS_STOP;
							end
						end
					end
					PMUI2C_HS_RX: begin
						if (!scl_r) begin
							scl_r <= 1'b1;
						end else begin
							scl_r <= 1'b0;
							bitn <= bitn + 4'h1;
							if (bitn < 4'h8) begin
								rx <= {rx[6:0], sda_sync[1]};
							end
							if (bitn == 4'h7) begin
								rd_data <= {rx[6:0], sda_sync[1]};
								rd_valid <= 1'b1;
							end
							if (bitn == 4'h8) begin
								bitn <= 4'h0;
								left <= left - 4'h1;
								st <= (left == 4'h0) ? PMUI2C_HS_STOP : PMUI2C_HS_RX;
							end
						end
					end
					PMUI2C_HS_RSTART: begin
						if (!scl_r && !sda_r) begin
							sda_r <= 1'b1;
						end else if (!scl_r) begin
							scl_r <= 1'b1;
						end else begin
							sda_r <= 1'b0;
							st <= PMUI2C_HS_START;
						end
					end
					PMUI2C_HS_STOP: begin
						if (!scl_r) begin
							if (sda_r) begin
								sda_r <= 1'b0;
							end else begin
								scl_r <= 1'b1;
							end
						end else begin
							sda_r <= 1'b1;
							st <= PMUI2C_HS_IDLE;
						end
					end
					default: st <= PMUI2C_HS_IDLE;
				endcase
			end
		end
	end

	// Master pulls SDA low only; SCL push-pull
	always_comb begin
		bus.scl_o = scl_r;
		bus.scl_oe = 1'b1;
		bus.sda_m_o = 1'b0;
		bus.sda_m_oe = !sda_r;
	end
endmodule : pmui2c_host

// ==== rtl/pmui2c_map.svh ====
`ifndef PMUI2C_MAP_SVH
`define PMUI2C_MAP_SVH
// Device identifier; value is arbitrary
`define PMUI2C_DEV_ID 7'h2a
// Upper five bits of the high-speed master code
`define PMUI2C_MCODE_HI 5'h01
`define PMUI2C_ADDR_W 6
`define PMUI2C_NREGS 64
`define PMUI2C_SYS_HZ 40000000
// Bit rate of the host's own link clock
`define PMUI2C_LINK_HZ 400000
`define PMUI2C_HALF_CYC (`PMUI2C_SYS_HZ / (2 * `PMUI2C_LINK_HZ))
// Host command codes
`define PMUI2C_CMD_WRITE 2'h0
`define PMUI2C_CMD_READ 2'h1
`define PMUI2C_CMD_CUR_READ 2'h2
`define PMUI2C_CMD_HS 2'h3
`endif

// ==== rtl/pmui2c_pkg.sv ====
package pmui2c_pkg;
	typedef enum logic [5:0] {
		PMUI2C_ST_IDLE = 6'h01,
		PMUI2C_ST_SEL = 6'h02,
		PMUI2C_ST_ADDR = 6'h04,
		PMUI2C_ST_WDATA = 6'h08,
		PMUI2C_ST_RDATA = 6'h10,
		PMUI2C_ST_ACK = 6'h20
	} pmui2c_state_e;
	typedef enum logic [6:0] {
		PMUI2C_HS_IDLE = 7'h01,
		PMUI2C_HS_START = 7'h02,
		PMUI2C_HS_TX = 7'h04,
		PMUI2C_HS_ACK = 7'h08,
		PMUI2C_HS_RX = 7'h10,
		PMUI2C_HS_RSTART = 7'h20,
		PMUI2C_HS_STOP = 7'h40
	} pmui2c_hstate_e;
endpackage : pmui2c_pkg

// ==== testbench/pmui2c_monitor.sv ====
`timescale 1ns/1ps
`include "pmui2c_map.svh"
module pmui2c_monitor
	import pmui2c_pkg::*;
#(
	parameter logic [6:0] DEV_ID = `PMUI2C_DEV_ID
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_o,
	input wire logic sda_s_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic scl_q, sda_q, first, match, rd, idle, desel, nak;
	logic [3:0] cnt;
	logic [7:0] sh;
	wire dev_low = sda_s_oe && !sda_s_o;
	wire start = scl && scl_q && sda_q && !sda;
	wire stop = scl && scl_q && !sda_q && sda;
	wire rise = scl && !scl_q;
	wire ninth = rise && cnt == 4'h8;
	wire hit = sh[7:1] == DEV_ID;
	wire mcode = sh[7:3] == `PMUI2C_MCODE_HI;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cnt <= 4'h0;
			sh <= 8'h00;
			first <= 1'b0;
			match <= 1'b0;
			rd <= 1'b0;
			idle <= 1'b1;
			desel <= 1'b0;
			nak <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start || stop) begin
				cnt <= 4'h0;
				first <= start;
				idle <= stop;
				desel <= 1'b0;
				nak <= 1'b0;
			end else if (rise) begin
				cnt <= ninth ? 4'h0 : cnt + 4'h1;
				sh <= ninth ? sh : {sh[6:0], sda};
				if (ninth && first) begin
					first <= 1'b0;
					match <= hit;
					rd <= sh[0];
					desel <= !hit;
				end
				// Master left the ninth bit high after a byte we sent
				if (ninth && !first && match && rd && sda)
					nak <= 1'b1;
			end
		end
	end
	property p_od;
		sda_s_oe |-> !sda_s_o;
	endproperty
	a_od: assert property (p_od) else $error("device data drive not open drain");
	// Device sees SCL through a synchroniser, so its edges must land well inside the low phase
	property p_dev_edge;
		$changed(dev_low) |-> !scl && !$past(scl);
	endproperty
	a_dev_edge: assert property (p_dev_edge) else $error("device data changed near SCL high");
	property p_sel_ack;
		ninth && first && hit |-> !sda [*3];
	endproperty
	a_sel_ack: assert property (p_sel_ack) else $error("matching select not acknowledged");
	property p_mcode;
		ninth && first && mcode |-> sda ##1 sda;
	endproperty
	a_mcode: assert property (p_mcode) else $error("master code acknowledged");
	property p_wr_ack;
		ninth && !first && match && !rd |-> !sda;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
	property p_idle;
		idle |-> !dev_low;
	endproperty
	a_idle: assert property (p_idle) else $error("device drove bus outside a transfer");
	property p_desel;
		desel |-> !dev_low;
	endproperty
	a_desel: assert property (p_desel) else $error("deselected device drove bus");
	property p_nak;
		nak |-> !dev_low;
	endproperty
	a_nak: assert property (p_nak) else $error("device kept sending after master nack");
	c_hs: cover property (ninth && first && mcode);
	c_nak: cover property (ninth && !first && rd && sda);
	c_desel: cover property ($rose(desel));
endmodule : pmui2c_monitor

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "pmui2c_map.svh"
module tb
	import pmui2c_pkg::*;
;
	localparam logic [6:0] DEV = `PMUI2C_DEV_ID;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [6:0] cmd_dev = 7'h00;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic [3:0] cmd_len = 4'h0;
	logic cmd_ready, rd_valid, nack, reg_wr, hs_mode, busy, hs_seen, busy_seen;
	logic [7:0] rd_data, reg_wdata;
	logic [5:0] reg_addr;
	logic [7:0] rq[$];
	logic [13:0] wq[$];
	int bad_count = 0;
	int tests_run = 0;
	pmui2c_bus_if bus ();
	pmui2c_device i_pmui2c_device (.clk_sys, .rst_n, .bus(bus), .reg_addr, .reg_wdata, .reg_wr, .hs_mode, .busy);
	// Short half bit keeps the run brief; device still has room to see every edge
	pmui2c_host #(.HALF_CYC(8)) i_pmui2c_host (.clk_sys, .rst_n, .bus(bus), .cmd_valid, .cmd_op, .cmd_dev,
		.cmd_addr, .cmd_wdata, .cmd_len, .cmd_ready, .rd_data, .rd_valid, .nack);
	pmui2c_monitor #(.DEV_ID(DEV)) i_pmui2c_monitor (.clk_sys, .rst_n, .scl(bus.scl), .sda(bus.sda),
		.sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe));
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (reg_wr === 1'b1)
			wq.push_back({reg_addr, reg_wdata});
	end
	task automatic report_and_stop();
		if (bad_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask : chk_bit
	task automatic exp_wr(input logic [5:0] a, input logic [7:0] d);
		logic [13:0] w;
		w = (wq.size() > 0) ? wq.pop_front() : 14'bx;
		chk_byte({2'h0, w[13:8]}, {2'h0, a});
		chk_byte(w[7:0], d);
	endtask : exp_wr
	task automatic tick(inout int n);
		@(posedge clk_sys);
		n++;
		if (n > 20000) begin
			bad_count++;
			report_and_stop();
		end
	endtask : tick
	task automatic do_cmd(input logic [1:0] op, input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] len);
		int n;
		n = 0;
		rq.delete();
		hs_seen = 1'b0;
		busy_seen = 1'b0;
		while (cmd_ready !== 1'b1)
			tick(n);
		#1;
		cmd_op = op;
		cmd_dev = dev;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_len = len;
		cmd_valid = 1'b1;
		// Command is owned by the host once its start reaches the bus
		while (bus.sda !== 1'b0)
			tick(n);
		#1;
		cmd_valid = 1'b0;
		while (cmd_ready !== 1'b1) begin
			tick(n);
			if (rd_valid === 1'b1)
				rq.push_back(rd_data);
			hs_seen |= (hs_mode === 1'b1);
			busy_seen |= (busy === 1'b1);
		end
	endtask : do_cmd
	initial begin
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		do_cmd(`PMUI2C_CMD_WRITE, DEV, 8'hff, 8'hff, 4'h1);
		chk_bit(nack, 1'b0);
		chk_bit(busy_seen, 1'b1);
		exp_wr(6'h3f, 8'hdf);
		exp_wr(6'h00, 8'hdf);
		do_cmd(`PMUI2C_CMD_WRITE, DEV, 8'h01, 8'h21, 4'h1);
		exp_wr(6'h01, 8'h01);
		exp_wr(6'h02, 8'h01);
		do_cmd(`PMUI2C_CMD_READ, DEV, 8'h3f, 8'h00, 4'h1);
		chk_byte(8'(rq.size()), 8'h02);
		chk_byte(rq[0], 8'hdf);
		chk_byte(rq[1], 8'hdf);
		do_cmd(`PMUI2C_CMD_CUR_READ, DEV, 8'h00, 8'h00, 4'h0);
		chk_byte(rq[0], 8'h01);
		do_cmd(`PMUI2C_CMD_HS, DEV, 8'h00, 8'h00, 4'h0);
		chk_bit(hs_seen, 1'b1);
		chk_byte(rq[0], 8'h01);
		do_cmd(`PMUI2C_CMD_WRITE, DEV ^ 7'h01, 8'h05, 8'h11, 4'h0);
		chk_bit(hs_seen, 1'b0);
		chk_bit(nack, 1'b1);
		chk_byte(8'(wq.size()), 8'h00);
		do_cmd(`PMUI2C_CMD_WRITE, DEV, 8'h05, 8'h11, 4'h0);
		exp_wr(6'h05, 8'h11);
		report_and_stop();
	end
endmodule : tb
